//--- inc/wofuse_pkg.sv
// constants, register map, state codes and helpers for the wiper output fuse
// How it works
// - two independent channels, each with own settings, timers, retry count and fault
// - ignore peak current for 20 us after turn-on, then 75 A or more trips
// - current not below continuous limit at end of window trips; window 0.15 to 155 ms
// - continuous limit selectable: 7.5 A, 10 A, 12.5 A up to 25 A
// - per-channel arm delay from turn-on, at most 10 s, enables steady fuse
// - after arm delay, current above fuse level longer than grace time trips
// - grace time set in ms from 25 to 250 ms
// - tripped channel restarts automatically up to retry maximum, under 10 advised
// - automatic restarts are spaced by a retry interval in ms
// - measured current of each channel readable in mA
// - manual mode ignores events, starts all off, each command toggles a channel
// - any fault switches the fault lamp output on
// - reset event from the selected source clears fault of every latched channel
// - fault reset never restarts the unit or touches channels in normal operation
// - only channels latched off after exhausted retries are restarted
// - fault reset restarts channels tripped by peak, continuous or fuse protection
// - reset source selectable: pin, bus, event input or fault lamp output
package wofuse_pkg;
  localparam int unsigned NUM_CH = 2;
  // timebase
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned US_NS = 1000;
  localparam logic [6:0] US_CYCLES = 7'(US_NS / CLK_PERIOD_NS);
  localparam logic [9:0] US_PER_MS = 10'h3E8;
  // widths
  localparam int unsigned CUR_W = 17;
  localparam int unsigned WIN_W = 18;
  localparam int unsigned ARM_W = 14;
  localparam int unsigned GRC_W = 8;
  localparam int unsigned RMAX_W = 4;
  localparam int unsigned RMS_W = 16;
  localparam int unsigned SEL_W = 3;
  // protection figures
  localparam int unsigned INRUSH_TIME_US = 20;
  localparam logic [WIN_W-1:0] INRUSH_TICKS = WIN_W'(INRUSH_TIME_US);
  localparam logic [CUR_W-1:0] PEAK_LIMIT_MA = 17'h124F8;
  localparam logic [WIN_W-1:0] WIN_MIN_US = 18'h00096;
  localparam logic [WIN_W-1:0] WIN_MAX_US = 18'h25D78;
  localparam logic [ARM_W-1:0] ARM_MAX_MS = 14'h2710;
  localparam logic [GRC_W-1:0] GRACE_MIN_MS = 8'h19;
  localparam logic [GRC_W-1:0] GRACE_MAX_MS = 8'hFA;
  localparam logic [CUR_W-1:0] CONT_LIM_0_MA = 17'h01D4C;
  localparam logic [CUR_W-1:0] CONT_LIM_1_MA = 17'h02710;
  localparam logic [CUR_W-1:0] CONT_LIM_2_MA = 17'h030D4;
  localparam logic [CUR_W-1:0] CONT_STEP_MA = 17'h009C4;
  localparam logic [SEL_W-1:0] CONT_SEL_STEP0 = 3'h2;
  // reset values of channel settings
  localparam logic [SEL_W-1:0] RST_CONT_SEL = 3'h2;
  localparam logic [WIN_W-1:0] RST_WIN_US = 18'h02710;
  localparam logic [ARM_W-1:0] RST_ARM_MS = 14'h01F4;
  localparam logic [GRC_W-1:0] RST_GRACE_MS = 8'h64;
  localparam logic [CUR_W-1:0] RST_FUSE_MA = 17'h032C8;
  localparam logic [RMAX_W-1:0] RST_RETRY_MAX = 4'h3;
  localparam logic [RMS_W-1:0] RST_RETRY_INTERVAL = 16'h03E8;
  // register map
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_MANUAL = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_CUR0 = 12'h00C;
  localparam logic [11:0] OFS_CUR1 = 12'h010;
  localparam logic [11:0] OFS_SWRST = 12'h014;
  localparam logic [11:0] OFS_CH_BASE = 12'h020;
  localparam logic [11:0] OFS_CH_END = 12'h060;
  localparam int unsigned CH_SEL_BIT = 6;
  localparam int unsigned REG_IDX_MSB = 4;
  localparam int unsigned REG_IDX_LSB = 2;
  localparam logic [2:0] RG_CONT_SEL = 3'h0;
  localparam logic [2:0] RG_WIN_US = 3'h1;
  localparam logic [2:0] RG_ARM_MS = 3'h2;
  localparam logic [2:0] RG_GRACE_MS = 3'h3;
  localparam logic [2:0] RG_FUSE_MA = 3'h4;
  localparam logic [2:0] RG_RETRY_MAX = 3'h5;
  localparam logic [2:0] RG_RETRY_INTERVAL = 3'h6;
  localparam logic [2:0] RG_CH_STAT = 3'h7;
  // reset source selection
  localparam logic [1:0] SRC_PIN = 2'h0;
  localparam logic [1:0] SRC_LAMP = 2'h1;
  localparam logic [1:0] SRC_BUS = 2'h2;
  localparam logic [1:0] SRC_EVENT = 2'h3;

  typedef enum logic [3:0] {
    CH_OFF = 4'b0001,
    CH_ON = 4'b0010,
    CH_WAIT = 4'b0100,
    CH_LATCH = 4'b1000
  } wofuse_state_t;

  // continuous limit in mA for a selection code
  function automatic logic [CUR_W-1:0] wofuse_cont_limit(input logic [SEL_W-1:0] sel);
    if (sel == 3'h0) return CONT_LIM_0_MA;
    else if (sel == 3'h1) return CONT_LIM_1_MA;
    else return CUR_W'(CONT_LIM_2_MA + CUR_W'(sel - CONT_SEL_STEP0) * CONT_STEP_MA);
  endfunction

  // keep a setting inside its allowed range
  function automatic logic [31:0] wofuse_clamp(input logic [31:0] v, input logic [31:0] lo,
                                               input logic [31:0] hi);
    if (v < lo) return lo;
    else if (v > hi) return hi;
    else return v;
  endfunction
endpackage

//--- design/wofuse_chan.sv
// one protected wiper output channel with its timers and retry logic
`timescale 1ns/1ns
module wofuse_chan import wofuse_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic us_tick,
  input wire logic ms_tick,
  input wire logic demand,
  input wire logic [CUR_W-1:0] cur_ma,
  input wire logic [SEL_W-1:0] cont_sel,
  input wire logic [WIN_W-1:0] win_us,
  input wire logic [ARM_W-1:0] arm_ms,
  input wire logic [GRC_W-1:0] grace_ms,
  input wire logic [CUR_W-1:0] fuse_ma,
  input wire logic [RMAX_W-1:0] retry_max,
  input wire logic [RMS_W-1:0] retry_interval,
  input wire logic fault_clear,
  output logic drive,
  output logic fault,
  output logic latched,
  output logic [2:0] cause,
  output logic [RMAX_W-1:0] retries
);
  typedef struct packed {
    wofuse_state_t state;
    logic [WIN_W-1:0] us_cnt;
    logic [ARM_W-1:0] ms_cnt;
    logic [GRC_W:0] grace_cnt;
    logic [RMS_W-1:0] wait_cnt;
    logic [RMAX_W-1:0] retries;
    logic [2:0] cause;
    logic drive;
    logic fault;
    logic latched;
  } wofuse_chan_st_t;

  wofuse_chan_st_t r;
  wofuse_chan_st_t n;
  logic over_peak;
  logic over_cont;
  logic over_sw;
  logic trip;

  // protection checks and channel sequencing
  always_comb begin
    n = r;
    over_peak = (r.us_cnt >= INRUSH_TICKS) && (cur_ma >= PEAK_LIMIT_MA);
    over_cont = (r.us_cnt >= win_us) && (cur_ma >= wofuse_cont_limit(cont_sel));
    over_sw = (r.ms_cnt >= arm_ms) && (cur_ma > fuse_ma);
    trip = over_peak || over_cont || (over_sw && (r.grace_cnt > {1'b0, grace_ms}));
    case (r.state)
      CH_OFF: begin
        n.drive = 1'b0;
        if (demand) begin
          n.state = CH_ON;
          n.drive = 1'b1;
          n.us_cnt = '0;
          n.ms_cnt = '0;
          n.grace_cnt = '0;
        end
      end
      CH_ON: begin
        if (us_tick && (r.us_cnt != WIN_MAX_US)) n.us_cnt = WIN_W'(r.us_cnt + 1'b1);
        if (ms_tick && (r.ms_cnt != ARM_MAX_MS)) n.ms_cnt = ARM_W'(r.ms_cnt + 1'b1);
        if (!over_sw) n.grace_cnt = '0;
        else if (ms_tick && (r.grace_cnt != '1)) n.grace_cnt = (GRC_W+1)'(r.grace_cnt + 1'b1);
        if (!demand) begin
          n.state = CH_OFF;
          n.drive = 1'b0;
          n.retries = '0;
        end else if (trip) begin
          n.drive = 1'b0;
          n.fault = 1'b1;
          n.cause = {over_sw, over_cont, over_peak};
          n.wait_cnt = '0;
          if (r.retries < retry_max) begin
            n.state = CH_WAIT;
            n.retries = RMAX_W'(r.retries + 1'b1);
          end else begin
            n.state = CH_LATCH;
            n.latched = 1'b1;
          end
        end
      end
      CH_WAIT: begin
        // retry interval counted in ms
        if (ms_tick) n.wait_cnt = RMS_W'(r.wait_cnt + 1'b1);
        if (r.wait_cnt >= retry_interval) begin
          n.fault = 1'b0;
          n.state = demand ? CH_ON : CH_OFF;
          n.drive = demand;
          n.us_cnt = '0;
          n.ms_cnt = '0;
          n.grace_cnt = '0;
        end
      end
      CH_LATCH: begin
        if (fault_clear) begin
          n.fault = 1'b0;
          n.latched = 1'b0;
          n.cause = '0;
          n.retries = '0;
          n.state = demand ? CH_ON : CH_OFF;
          n.drive = demand;
          n.us_cnt = '0;
          n.ms_cnt = '0;
          n.grace_cnt = '0;
        end
      end
      default: begin
        n.state = CH_OFF;
        n.drive = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{state: CH_OFF, default: '0};
    end else begin
      r <= n;
    end
  end

  assign drive = r.drive;
  assign fault = r.fault;
  assign latched = r.latched;
  assign cause = r.cause;
  assign retries = r.retries;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_on_steady;
    (r.state == CH_ON) && demand;
  endsequence

  chk_inrush_hold: assert property (s_on_steady and (r.us_cnt < INRUSH_TICKS) |=> drive)
    else $error("channel dropped during inrush blanking");
  chk_peak_trip: assert property (s_on_steady and over_peak |=> !drive && (r.state != CH_ON))
    else $error("peak overcurrent did not trip");
  chk_cont_trip: assert property (s_on_steady and (r.us_cnt >= win_us) &&
                                  (cur_ma >= wofuse_cont_limit(cont_sel)) |=> cause[1])
    else $error("continuous overcurrent did not trip");
  chk_grace_trip: assert property (s_on_steady and over_sw && (r.grace_cnt > {1'b0, grace_ms})
                                   |=> !drive ##0 cause[2])
    else $error("fuse overcurrent past grace did not trip");
  chk_retry_bound: assert property (retries <= retry_max || r.state == CH_OFF)
    else $error("retry count above maximum");
  chk_retry_wait: assert property ((r.state == CH_WAIT) |-> !drive && fault)
    else $error("channel driven during retry wait");
  chk_latch_hold: assert property ((r.state == CH_LATCH) && !fault_clear |=>
                                   (r.state == CH_LATCH) && latched && !drive)
    else $error("latched channel left latch without reset");
  chk_latch_restart: assert property ((r.state == CH_LATCH) && fault_clear && demand |=>
                                      drive && (retries == '0) && !fault)
    else $error("latched channel not restarted by fault reset");
  chk_reset_scope: assert property (s_on_steady and !trip && fault_clear |=>
                                    drive && $stable(retries))
    else $error("fault reset touched a healthy channel");
endmodule // wofuse_chan

//--- design/wofuse_top.sv
// wiper output electronic fuse: apb registers, timebase, reset event and two channels
`timescale 1ns/1ns
module wofuse_top import wofuse_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CH-1:0] event_demand,
  input wire logic [CUR_W-1:0] current_one_ma,
  input wire logic [CUR_W-1:0] current_two_ma,
  input wire logic fault_reset_n,
  input wire logic event_reset_n,
  output logic wiper_channel_one,
  output logic wiper_channel_two,
  output logic fault_lamp_output
);
  typedef struct packed {
    logic [NUM_CH-1:0] req_s1;
    logic [NUM_CH-1:0] req_s2;
    logic [NUM_CH-1:0][CUR_W-1:0] cur_s1;
    logic [NUM_CH-1:0][CUR_W-1:0] cur_s2;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic ev_s1;
    logic ev_s2;
    logic ev_s3;
    logic lamp_prev;
    logic bus_rst;
    logic fault_clear;
    logic [6:0] us_div;
    logic [9:0] ms_div;
    logic us_tick;
    logic ms_tick;
    logic manual;
    logic [1:0] rst_src;
    logic [NUM_CH-1:0] manual_on;
    logic [NUM_CH-1:0][SEL_W-1:0] cont_sel;
    logic [NUM_CH-1:0][WIN_W-1:0] win_us;
    logic [NUM_CH-1:0][ARM_W-1:0] arm_ms;
    logic [NUM_CH-1:0][GRC_W-1:0] grace_ms;
    logic [NUM_CH-1:0][CUR_W-1:0] fuse_ma;
    logic [NUM_CH-1:0][RMAX_W-1:0] retry_max;
    logic [NUM_CH-1:0][RMS_W-1:0] retry_interval;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic lamp;
  } wofuse_top_st_t;

  wofuse_top_st_t r;
  wofuse_top_st_t n;
  logic [NUM_CH-1:0] demand;
  logic [NUM_CH-1:0] ch_drive;
  logic [NUM_CH-1:0] ch_fault;
  logic [NUM_CH-1:0] ch_latched;
  logic [NUM_CH-1:0][2:0] ch_cause;
  logic [NUM_CH-1:0][RMAX_W-1:0] ch_retries;
  logic ch_idx;
  logic [2:0] reg_idx;
  logic in_ch_space;
  logic access_wr;
  logic reset_event;

  // channel demand: events normally, manual toggles in test mode
  assign demand = r.manual ? r.manual_on : r.req_s2;

  // everything except the channels themselves
  always_comb begin
    n = r;
    ch_idx = paddr[CH_SEL_BIT];
    reg_idx = paddr[REG_IDX_MSB:REG_IDX_LSB];
    in_ch_space = (paddr >= OFS_CH_BASE) && (paddr < OFS_CH_END);
    access_wr = psel && penable && r.pready && pwrite && !r.pslverr;
    reset_event = 1'b0;

    // two flip-flop synchronisers for demand, current and reset inputs
    n.req_s1 = event_demand;
    n.req_s2 = r.req_s1;
    n.cur_s1 = {current_two_ma, current_one_ma};
    n.cur_s2 = r.cur_s1;
    n.pin_s1 = fault_reset_n;
    n.pin_s2 = r.pin_s1;
    n.pin_s3 = r.pin_s2;
    n.ev_s1 = event_reset_n;
    n.ev_s2 = r.ev_s1;
    n.ev_s3 = r.ev_s2;
    n.lamp_prev = r.lamp;

    // microsecond and millisecond ticks
    n.us_tick = 1'b0;
    n.ms_tick = 1'b0;
    if (r.us_div == 7'(US_CYCLES - 1'b1)) begin
      n.us_div = '0;
      n.us_tick = 1'b1;
      if (r.ms_div == 10'(US_PER_MS - 1'b1)) begin
        n.ms_div = '0;
        n.ms_tick = 1'b1;
      end else begin
        n.ms_div = 10'(r.ms_div + 1'b1);
      end
    end else begin
      n.us_div = 7'(r.us_div + 1'b1);
    end

    // one reset action per asserting edge of the selected source
    if (r.rst_src == SRC_PIN) begin
      reset_event = r.pin_s3 && !r.pin_s2;
    end else if (r.rst_src == SRC_LAMP) begin
      reset_event = r.lamp && !r.lamp_prev;
    end else if (r.rst_src == SRC_BUS) begin
      reset_event = r.bus_rst;
    end else begin
      reset_event = r.ev_s3 && !r.ev_s2;
    end
    n.fault_clear = reset_event;
    n.bus_rst = 1'b0;

    // fault lamp on while any channel is in error
    n.lamp = |ch_fault;

    // manual state starts off whenever manual mode is not active
    if (!r.manual) n.manual_on = '0;

    // apb setup: decode and prepare the answer for the access cycle
    n.pready = 1'b0;
    if (psel && !penable) begin
      n.pready = 1'b1;
      n.pslverr = 1'b0;
      n.prdata = '0;
      if (paddr[REG_IDX_LSB-1:0] != 2'h0) begin
        n.pslverr = 1'b1;
      end else if (paddr == OFS_CTRL) begin
        n.prdata = 32'({r.rst_src, r.manual});
      end else if (paddr == OFS_MANUAL) begin
        n.prdata = 32'(r.manual_on);
      end else if (paddr == OFS_STATUS) begin
        n.prdata = 32'({ch_latched, ch_fault, ch_drive, r.lamp});
      end else if (paddr == OFS_CUR0) begin
        n.prdata = 32'(r.cur_s2[0]);
      end else if (paddr == OFS_CUR1) begin
        n.prdata = 32'(r.cur_s2[1]);
      end else if (paddr == OFS_SWRST) begin
        n.prdata = '0;
      end else if (in_ch_space) begin
        if (reg_idx == RG_CONT_SEL) n.prdata = 32'(r.cont_sel[ch_idx]);
        else if (reg_idx == RG_WIN_US) n.prdata = 32'(r.win_us[ch_idx]);
        else if (reg_idx == RG_ARM_MS) n.prdata = 32'(r.arm_ms[ch_idx]);
        else if (reg_idx == RG_GRACE_MS) n.prdata = 32'(r.grace_ms[ch_idx]);
        else if (reg_idx == RG_FUSE_MA) n.prdata = 32'(r.fuse_ma[ch_idx]);
        else if (reg_idx == RG_RETRY_MAX) n.prdata = 32'(r.retry_max[ch_idx]);
        else if (reg_idx == RG_RETRY_INTERVAL) n.prdata = 32'(r.retry_interval[ch_idx]);
        else n.prdata = 32'({ch_cause[ch_idx], ch_retries[ch_idx]});
      end else begin
        n.pslverr = 1'b1;
      end
    end

    // apb access: writes take effect on the completing edge
    if (access_wr) begin
      if (paddr == OFS_CTRL) begin
        n.manual = pwdata[0];
        n.rst_src = pwdata[2:1];
        if (pwdata[0] && !r.manual) n.manual_on = '0;
      end else if (paddr == OFS_MANUAL) begin
        if (r.manual) n.manual_on = r.manual_on ^ pwdata[NUM_CH-1:0];
      end else if (paddr == OFS_SWRST) begin
        n.bus_rst = pwdata[0];
      end else if (in_ch_space) begin
        if (reg_idx == RG_CONT_SEL) begin
          n.cont_sel[ch_idx] = pwdata[SEL_W-1:0];
        end else if (reg_idx == RG_WIN_US) begin
          n.win_us[ch_idx] = WIN_W'(wofuse_clamp(pwdata, 32'(WIN_MIN_US),
                                                 32'(WIN_MAX_US)));
        end else if (reg_idx == RG_ARM_MS) begin
          n.arm_ms[ch_idx] = ARM_W'(wofuse_clamp(pwdata, 32'h0,
                                                 32'(ARM_MAX_MS)));
        end else if (reg_idx == RG_GRACE_MS) begin
          n.grace_ms[ch_idx] = GRC_W'(wofuse_clamp(pwdata, 32'(GRACE_MIN_MS),
                                                   32'(GRACE_MAX_MS)));
        end else if (reg_idx == RG_FUSE_MA) begin
          n.fuse_ma[ch_idx] = pwdata[CUR_W-1:0];
        end else if (reg_idx == RG_RETRY_MAX) begin
          n.retry_max[ch_idx] = pwdata[RMAX_W-1:0];
        end else if (reg_idx == RG_RETRY_INTERVAL) begin
          n.retry_interval[ch_idx] = pwdata[RMS_W-1:0];
        end
      end
    end
  end

  // state register with documented reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.pin_s1 <= 1'b1;
      r.pin_s2 <= 1'b1;
      r.pin_s3 <= 1'b1;
      r.ev_s1 <= 1'b1;
      r.ev_s2 <= 1'b1;
      r.ev_s3 <= 1'b1;
      r.cont_sel <= {NUM_CH{RST_CONT_SEL}};
      r.win_us <= {NUM_CH{RST_WIN_US}};
      r.arm_ms <= {NUM_CH{RST_ARM_MS}};
      r.grace_ms <= {NUM_CH{RST_GRACE_MS}};
      r.fuse_ma <= {NUM_CH{RST_FUSE_MA}};
      r.retry_max <= {NUM_CH{RST_RETRY_MAX}};
      r.retry_interval <= {NUM_CH{RST_RETRY_INTERVAL}};
    end else begin
      r <= n;
    end
  end

  // the two independent channels
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    wofuse_chan u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .us_tick(r.us_tick),
      .ms_tick(r.ms_tick),
      .demand(demand[g]),
      .cur_ma(r.cur_s2[g]),
      .cont_sel(r.cont_sel[g]),
      .win_us(r.win_us[g]),
      .arm_ms(r.arm_ms[g]),
      .grace_ms(r.grace_ms[g]),
      .fuse_ma(r.fuse_ma[g]),
      .retry_max(r.retry_max[g]),
      .retry_interval(r.retry_interval[g]),
      .fault_clear(r.fault_clear),
      .drive(ch_drive[g]),
      .fault(ch_fault[g]),
      .latched(ch_latched[g]),
      .cause(ch_cause[g]),
      .retries(ch_retries[g])
    );
  end

  // outputs straight from flip-flops
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign wiper_channel_one = ch_drive[0];
  assign wiper_channel_two = ch_drive[1];
  assign fault_lamp_output = r.lamp;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_apb_setup;
    psel && !penable;
  endsequence

  sequence s_pin_fall;
    (r.rst_src == SRC_PIN) && r.pin_s3 && !r.pin_s2;
  endsequence

  chk_apb_ready: assert property (s_apb_setup |=> pready ##1 !pready)
    else $error("apb answer not given in first access cycle");
  chk_lamp_fault: assert property ((|ch_fault) |=> fault_lamp_output)
    else $error("fault lamp off while a channel is in error");
  chk_lamp_clear: assert property (!(|ch_fault) |=> !fault_lamp_output)
    else $error("fault lamp on without a fault");
  chk_reset_once: assert property (s_pin_fall |=> r.fault_clear ##1 !r.fault_clear)
    else $error("pin reset edge did not give exactly one pulse");
  chk_reset_source: assert property ((r.rst_src != SRC_PIN) && (r.rst_src != SRC_EVENT) &&
                                     !r.bus_rst && !(r.lamp && !r.lamp_prev) |=> !r.fault_clear)
    else $error("fault reset without its selected source");
  chk_manual_off: assert property ($rose(r.manual) |-> (r.manual_on == '0))
    else $error("manual mode did not start with channels off");
  chk_manual_toggle: assert property (access_wr && r.manual && (paddr == OFS_MANUAL) |=>
                                      (r.manual_on == ($past(r.manual_on) ^ $past(pwdata[NUM_CH-1:0]))))
    else $error("manual command did not toggle channels");
  chk_grace_range: assert property ((r.grace_ms[0] >= GRACE_MIN_MS) && (r.grace_ms[0] <= GRACE_MAX_MS))
    else $error("grace time outside allowed range");
  chk_arm_range: assert property (r.arm_ms[1] <= ARM_MAX_MS)
    else $error("arm delay above limit");

  sequence s_ev_fall;
    (r.rst_src == SRC_EVENT) && r.ev_s3 && !r.ev_s2;
  endsequence

  // event input edge gives one clear pulse
  chk_event_once: assert property (s_ev_fall |=> r.fault_clear ##1 !r.fault_clear)
    else $error("event reset edge did not give exactly one pulse");

  // bus request clears when the bus is the source
  chk_bus_reset: assert property ((r.rst_src == SRC_BUS) && r.bus_rst |=> r.fault_clear)
    else $error("bus reset request ignored");

  // rising lamp clears when the lamp is the source
  chk_lamp_reset: assert property ((r.rst_src == SRC_LAMP) && r.lamp && !r.lamp_prev |=> r.fault_clear)
    else $error("lamp reset edge ignored");

  // microsecond tick only when the divider wraps
  chk_us_tick: assert property (r.us_tick |-> (r.us_div == '0))
    else $error("microsecond tick off its divider");

  // millisecond tick rides on a microsecond tick
  chk_ms_tick: assert property (r.ms_tick |-> r.us_tick && (r.ms_div == '0))
    else $error("millisecond tick off its divider");

  // current readout returns the synchronised word
  chk_cur_one_read: assert property (s_apb_setup and (paddr == OFS_CUR0) |=>
                                     (prdata == 32'($past(r.cur_s2[0]))))
    else $error("channel one current readout wrong");

  // same for channel two
  chk_cur_two_read: assert property (s_apb_setup and (paddr == OFS_CUR1) |=>
                                     (prdata == 32'($past(r.cur_s2[1]))))
    else $error("channel two current readout wrong");

  // manual mode with nothing toggled on keeps both outputs off
  chk_manual_hold: assert property (r.manual && (r.manual_on == '0) |=>
                                    !wiper_channel_one && !wiper_channel_two)
    else $error("output on in manual mode without a command");

  // a write to channel one leaves channel two settings alone
  chk_chan_indep: assert property (access_wr && in_ch_space && !ch_idx |=>
                                   $stable(r.win_us[1]) && $stable(r.retry_max[1]) && $stable(r.cont_sel[1]))
    else $error("channel one write changed channel two");

  // window of channel one stays at or above its minimum, of channel two at or below its maximum
  chk_win_range: assert property ((r.win_us[0] >= WIN_MIN_US) && (r.win_us[1] <= WIN_MAX_US))
    else $error("window outside allowed range");

  // refused writes change nothing
  chk_err_no_write: assert property (psel && penable && pwrite && pready && pslverr |=>
                                     $stable(r.rst_src) && $stable(r.manual))
    else $error("refused write took effect");

  // refused transfers read zero
  chk_err_zero: assert property (pready && pslverr |-> (prdata == '0))
    else $error("refused read returned data");

  // unaligned addresses are refused
  chk_unaligned_err: assert property (s_apb_setup and (paddr[REG_IDX_LSB-1:0] != 2'h0) |=> pslverr)
    else $error("unaligned access not refused");
endmodule // wofuse_top

//--- sim/wofuse_load.sv
// behavioural wiper motor load with current measurement
`timescale 1ns/1ns
module wofuse_load import wofuse_pkg::*; (
  input wire logic pclk,
  input wire logic drive,
  input wire logic [CUR_W-1:0] amp,
  output logic [CUR_W-1:0] cur_ma
);
  // current flows only while the output is switched on, zero once released
  always_ff @(posedge pclk) begin
    cur_ma <= drive ? amp : '0;
  end
endmodule // wofuse_load

//--- sim/wofuse_tb_top.sv
// self-checking bench for the wiper output electronic fuse
`timescale 1ns/1ns
module wofuse_tb_top import wofuse_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, frn, ern, w1, w2, lamp, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, seed;
  logic [1:0] dem;
  logic [CUR_W-1:0] amp1, amp2, c1, c2;
  int err_total, checked, e_lat;
  wofuse_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_demand(dem), .current_one_ma(c1), .current_two_ma(c2), .fault_reset_n(frn),
    .event_reset_n(ern), .wiper_channel_one(w1), .wiper_channel_two(w2), .fault_lamp_output(lamp));
  wofuse_load ld1_u (.pclk(pclk), .drive(w1), .amp(amp1), .cur_ma(c1));
  wofuse_load ld2_u (.pclk(pclk), .drive(w2), .amp(amp2), .cur_ma(c2));
  // 100 MHz clock
  always #5 pclk = ~pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #600000;
    err_total++;
    print_verdict();
  end
  // main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, dem, frn} = '0;
    frn = 1'b1;
    ern = 1'b1;
    amp1 = 17'h01388;
    amp2 = '0;
    seed = 32'hCA12;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h020, '0);
    chk(q, 32'h2);
    apb(1'b0, 12'h01C, '0);
    chk({31'h0, e}, 32'h1);
    seed = lfsr(seed);
    apb(1'b1, 12'h024, 32'h96);
    apb(1'b1, 12'h034, 32'h0);
    amp2 <= 17'(17'h003E8 + seed[11:0]);
    amp1 <= 17'h13880;
    dem <= 2'b11;
    repeat (1500) @(posedge pclk);
    chk({31'h0, w1}, 32'h1);
    repeat (1500) @(posedge pclk);
    e_lat = 1;
    chk({29'h0, w1, w2, lamp}, {29'h0, 1'b0, 1'b1, 1'(e_lat)});
    apb(1'b0, 12'h008, '0);
    chk(q, 32'h2D);
    apb(1'b0, 12'h03C, '0);
    chk(q, 32'h10);
    apb(1'b0, 12'h010, '0);
    chk(q, {15'h0, amp2});
    amp1 <= 17'h01388;
    frn <= 1'b0;
    repeat (3) @(posedge pclk);
    frn <= 1'b1;
    repeat (12) @(posedge pclk);
    e_lat = 0;
    chk({29'h0, w1, w2, lamp}, {29'h0, 1'b1, 1'b1, 1'(e_lat)});
    apb(1'b1, 12'h000, 32'h1);
    repeat (3) @(posedge pclk);
    chk({30'h0, w1, w2}, 32'h0);
    apb(1'b1, 12'h004, 32'h1);
    repeat (3) @(posedge pclk);
    chk({30'h0, w1, w2}, 32'h2);
    apb(1'b1, 12'h004, 32'h1);
    repeat (3) @(posedge pclk);
    chk({30'h0, w1, w2}, 32'h0);
    // continuous trip with one retry on channel two, cleared by the event input
    apb(1'b1, 12'h050, 32'h2EE0);
    apb(1'b1, 12'h020, 32'h3);
    apb(1'b1, 12'h044, 32'h96);
    apb(1'b1, 12'h054, 32'h1);
    apb(1'b1, 12'h058, 32'h0);
    amp2 <= 17'h04E20;
    apb(1'b1, 12'h000, 32'h6);
    repeat (32000) @(posedge pclk);
    apb(1'b0, 12'h05C, '0);
    chk(q, 32'h21);
    chk({29'h0, w1, w2, lamp}, 32'h5);
    ern <= 1'b0;
    repeat (3) @(posedge pclk);
    ern <= 1'b1;
    repeat (12) @(posedge pclk);
    chk({29'h0, w1, w2, lamp}, 32'h6);
    apb(1'b0, 12'h05C, '0);
    chk(q, 32'h0);
    print_verdict();
  end
endmodule // wofuse_tb_top
